// [shared/pll_cfg_regs.svh]
/*
 Register indices, field positions, reset values and the glitch rejection time of the
 serial configuration port. Assumes inclusion from the design and the testbench.
*/
`ifndef PLL_CFG_REGS_SVH
`define PLL_CFG_REGS_SVH
// Register indices carried in the index byte
`define IDX_LOOP_PUMP   8'h00
`define IDX_REFDIV_FBHI 8'h01
`define IDX_FB_DIVS     8'h02
// Fixed upper five slave address bits
`define SLAVE_ADDR_HI   5'h15
// Register 0 fields
`define CAP_MSB   9
`define CAP_LSB   7
`define RES_MSB   6
`define RES_LSB   4
`define PUMP_MSB  3
`define PUMP_LSB  1
// Register 1 and 2 fields
`define REFDIV_MSB 15
`define REFDIV_LSB 2
`define FBA_HI_MSB 1
`define FBA_LO_MSB 15
`define FBA_LO_LSB 8
`define FBB_MSB    7
// Reset values
`define CAP_RST    3'h0
`define RES_RST    3'h0
`define PUMP_RST   3'h0
`define REFDIV_RST 14'h0000
`define FBA_RST    10'h000
`define FBB_RST    8'h00
// Glitch rejection time in ns
`define GLITCH_NS  50
`endif

// [shared/pll_cfg_pkg.sv]
/*
 Types of the serial configuration port: engine states and the word that
 carries the configuration across clock domains. Assumes no surroundings.
*/
package pll_cfg_pkg;
    // Protocol engine states, one-hot
    typedef enum logic [8:0] {
        ST_IDLE    = 9'h001,
        ST_ADDR    = 9'h002,
        ST_ADDR_AK = 9'h004,
        ST_INDEX   = 9'h008,
        ST_IDX_AK  = 9'h010,
        ST_WR      = 9'h020,
        ST_WR_AK   = 9'h040,
        ST_RD      = 9'h080,
        ST_RD_AK   = 9'h100
    } eng_state_t;
    // cap, res, pump, ref divider, feedback a, feedback b
    typedef logic [40:0] cfg_word_t;
endpackage

// [hdl/i2c_pll_cfg.sv]
/*
 Two-wire slave port and the first three PLL configuration registers.
 The protocol engine oversamples the bus pins on link_clk_i; the settings
 reach the sys_clk_i domain through a toggle handshake. Assumes a bus
 master on the pins and a free running link_clk_i.
*/
// Summary of operation
// - Answer only address 10101 followed by the two address-select pin levels.
// - Capture the address-select pins once after power-up and keep them.
// - Data line is open drain: pulled low or released, never driven high.
// - Data changes only while clock is low, one clock pulse per bit.
// - Start is data falling with clock high; stop is data rising.
// - Bytes are eight bits, MSB first, then one acknowledge slot.
// - Receiver pulls data low in the ninth pulse to acknowledge.
// - Address byte is seven address bits then direction, 1 read.
// - Acknowledge a matching address; otherwise stay released until next start.
// - On a read not-acknowledge, release data and return to idle.
// - Each register is 16 bits, moved as two bytes.
// - Twenty registers exist; only indices 0 to 2 are held here.
// - Register 0 bits 15:10 are written zero; bit 0 reads zero.
// - Register 0 bits 9:7 select the loop filter capacitor.
// - Register 0 bits 6:4 select the loop filter resistor.
// - Register 0 bits 3:1 select charge pump current.
// - Register 1 bits 15:2 hold the 14-bit reference divider.
// - Feedback divider a: bits 9:8 in register 1, 7:0 in register 2.
// - Register 2 bits 7:0 hold the 8-bit feedback divider b.
// - Port is active only with interface select high pin 0, low pin 1.
// - Pulses on clock and data shorter than 50 ns are ignored.
// - No response while the device reset pin is low.
`include "pll_cfg_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module i2c_pll_cfg
    import pll_cfg_pkg::*;
#(
    parameter int LINK_CLK_MHZ = 167
)(
    input  wire logic        sys_clk_i,
    input  wire logic        srst_i,
    input  wire logic        link_clk_i,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_n_o,
    input  wire logic        addr_select_hi_pin_i,
    input  wire logic        addr_select_lo_pin_i,
    input  wire logic        iface_sel_hi_i,
    input  wire logic        iface_sel_lo_i,
    input  wire logic        device_reset_low_i,
    output logic [2:0]       loop_cap_sel_o,
    output logic [2:0]       loop_res_sel_o,
    output logic [2:0]       pump_current_sel_o,
    output logic [13:0]      ref_divider_o,
    output logic [9:0]       feedback_divider_a_o,
    output logic [7:0]       feedback_divider_b_o
);
    localparam int FILT_CYC = (`GLITCH_NS * LINK_CLK_MHZ + 999) / 1000;
    localparam logic [3:0] FILT_MAX = 4'(FILT_CYC);

    // Filter counter is four bits wide
    if (FILT_CYC < 1 || FILT_CYC > 15)
    begin : g_bad_clk
        $error("LINK_CLK_MHZ gives a glitch count outside 1..15");
    end

    logic       rst_s1, link_rst;
    logic [6:0] pin_s1, pin_s2;
    logic [1:0] filt, filt_q;
    logic       scl_f, sda_f, scl_rise, scl_fall, start_det, stop_det;
    logic       bus_en, addr_cap;
    logic [1:0] addr_lo;
    eng_state_t state;
    logic [3:0] bitcnt;
    logic [7:0] shreg, txb, idx;
    logic       rw, byte_hi, nack, drive_low, commit;
    logic [15:0] wr_word;
    logic [15:0] rd_cur, rd_nxt;
    logic [2:0] cap, res, pump;
    logic [13:0] refdiv;
    logic [9:0] fba;
    logic [7:0] fbb;
    logic       dirty, req_t, ack_s1, ack_s2;
    cfg_word_t  snap;
    logic       req_s1, req_s2, req_s3, ack_t;

    // Reset brought into the link domain
    always_ff @(posedge link_clk_i)
    begin
        rst_s1   <= srst_i;
        link_rst <= rst_s1;
    end

    // Two-stage synchronisers for every pin
    always_ff @(posedge link_clk_i)
    begin
        pin_s1 <= {sda_i, scl_i, addr_select_lo_pin_i, addr_select_hi_pin_i,
                   iface_sel_lo_i, iface_sel_hi_i, device_reset_low_i};
        pin_s2 <= pin_s1;
    end

    // Port enable from reset pin and interface select
    assign bus_en = pin_s2[0] & ~pin_s2[1] & pin_s2[2];

    // Glitch filter per bus line: follow input only after it stays put
    for (genvar i = 0; i < 2; i++)
    begin : g_filt
        logic [3:0] cnt;
        always_ff @(posedge link_clk_i)
        begin
            if (link_rst)
            begin
                cnt     <= 4'h0;
                filt[i] <= 1'b1;
            end
            else if (pin_s2[5 + i] == filt[i])
                cnt <= 4'h0;
            else if (cnt == FILT_MAX - 4'h1)
            begin
                cnt     <= 4'h0;
                filt[i] <= pin_s2[5 + i];
            end
            else
                cnt <= cnt + 4'h1;
        end
    end

    // Previous filtered levels for edge detection
    always_ff @(posedge link_clk_i)
    begin
        if (link_rst)
            filt_q <= 2'h3;
        else
            filt_q <= filt;
    end

    // Bus events
    assign scl_f     = filt[0];
    assign sda_f     = filt[1];
    assign scl_rise  = scl_f & ~filt_q[0];
    assign scl_fall  = ~scl_f & filt_q[0];
    assign start_det = scl_f & filt_q[0] & filt_q[1] & ~sda_f;
    assign stop_det  = scl_f & filt_q[0] & ~filt_q[1] & sda_f;

    // Address pins caught once after reset release
    always_ff @(posedge link_clk_i)
    begin
        if (link_rst)
            addr_cap <= 1'b0;
        else if (!addr_cap)
        begin
            addr_cap <= 1'b1;
            addr_lo  <= {pin_s2[3], pin_s2[4]};
        end
    end

    // Readback word of the addressed register
    function automatic logic [15:0] rd_word(input logic [7:0] i);
        logic [15:0] w;
        w = 16'h0000;
        case (i)
            `IDX_LOOP_PUMP:   w = {6'h00, cap, res, pump, 1'b0};
            `IDX_REFDIV_FBHI: w = {refdiv, fba[9:8]};
            `IDX_FB_DIVS:     w = {fba[7:0], fbb};
            default:          w = 16'h0000;
        endcase
        return w;
    endfunction

    // Words of the addressed register and of the one after it
    always_comb
    begin
        rd_cur = rd_word(idx);
        rd_nxt = rd_word(idx + 8'h01);
    end

    // Protocol engine: state, bit count, shifting and line drive
    always_ff @(posedge link_clk_i)
    begin
        commit <= 1'b0;
        if (link_rst || !bus_en)
        begin
            state     <= ST_IDLE;
            bitcnt    <= 4'h0;
            drive_low <= 1'b0;
            byte_hi   <= 1'b1;
            nack      <= 1'b0;
            rw        <= 1'b0;
            idx       <= 8'h00;
        end
        else if (start_det)
        begin
            state     <= ST_ADDR;
            bitcnt    <= 4'h0;
            drive_low <= 1'b0;
        end
        else if (stop_det)
        begin
            state     <= ST_IDLE;
            drive_low <= 1'b0;
        end
        else
        begin
            case (state)
                ST_ADDR, ST_INDEX, ST_WR:
                begin
                    if (scl_rise)
                    begin
                        shreg  <= {shreg[6:0], sda_f};
                        bitcnt <= bitcnt + 4'h1;
                    end
                    else if (scl_fall && bitcnt == 4'h8)
                    begin
                        bitcnt    <= 4'h0;
                        drive_low <= 1'b1;
                        if (state == ST_INDEX)
                        begin
                            idx   <= shreg;
                            state <= ST_IDX_AK;
                        end
                        else if (state == ST_WR)
                        begin
                            if (byte_hi)
                                wr_word[15:8] <= shreg;
                            else
                                wr_word[7:0] <= shreg;
                            state <= ST_WR_AK;
                        end
                        else if (shreg[7:1] == {`SLAVE_ADDR_HI, addr_lo})
                        begin
                            rw    <= shreg[0];
                            state <= ST_ADDR_AK;
                        end
                        else
                        begin
                            drive_low <= 1'b0;
                            state     <= ST_IDLE;
                        end
                    end
                end
                ST_ADDR_AK, ST_IDX_AK, ST_WR_AK:
                begin
                    if (scl_fall)
                    begin
                        drive_low <= 1'b0;
                        byte_hi   <= 1'b1;
                        state     <= ST_WR;
                        if (state == ST_ADDR_AK && rw)
                        begin
                            txb       <= rd_cur[15:8];
                            drive_low <= ~rd_cur[15];
                            state     <= ST_RD;
                        end
                        else if (state == ST_ADDR_AK)
                            state <= ST_INDEX;
                        else if (state == ST_WR_AK && byte_hi)
                            byte_hi <= 1'b0;
                        else if (state == ST_WR_AK)
                        begin
                            commit <= 1'b1;
                            idx    <= idx + 8'h01;
                        end
                    end
                end
                ST_RD:
                begin
                    if (scl_fall)
                    begin
                        bitcnt <= bitcnt + 4'h1;
                        if (bitcnt == 4'h7)
                        begin
                            bitcnt    <= 4'h0;
                            drive_low <= 1'b0;
                            state     <= ST_RD_AK;
                        end
                        else
                        begin
                            txb       <= {txb[6:0], 1'b0};
                            drive_low <= ~txb[6];
                        end
                    end
                end
                ST_RD_AK:
                begin
                    if (scl_rise)
                        nack <= sda_f;
                    else if (scl_fall && nack)
                        state <= ST_IDLE;
                    else if (scl_fall)
                    begin
                        state <= ST_RD;
                        if (byte_hi)
                        begin
                            byte_hi   <= 1'b0;
                            txb       <= rd_cur[7:0];
                            drive_low <= ~rd_cur[7];
                        end
                        else
                        begin
                            byte_hi   <= 1'b1;
                            idx       <= idx + 8'h01;
                            txb       <= rd_nxt[15:8];
                            drive_low <= ~rd_nxt[15];
                        end
                    end
                end
                default:
                    drive_low <= 1'b0;
            endcase
        end
    end

    // Open-drain pad: only ever pulls low
    assign sda_o      = 1'b0;
    assign sda_oe_n_o = ~drive_low;

    // Configuration registers, written after a full word
    always_ff @(posedge link_clk_i)
    begin
        if (link_rst)
        begin
            cap    <= `CAP_RST;
            res    <= `RES_RST;
            pump   <= `PUMP_RST;
            refdiv <= `REFDIV_RST;
            fba    <= `FBA_RST;
            fbb    <= `FBB_RST;
        end
        else if (commit)
        begin
            case (idx - 8'h01)
                `IDX_LOOP_PUMP:
                begin
                    cap  <= wr_word[`CAP_MSB:`CAP_LSB];
                    res  <= wr_word[`RES_MSB:`RES_LSB];
                    pump <= wr_word[`PUMP_MSB:`PUMP_LSB];
                end
                `IDX_REFDIV_FBHI:
                begin
                    refdiv   <= wr_word[`REFDIV_MSB:`REFDIV_LSB];
                    fba[9:8] <= wr_word[`FBA_HI_MSB:0];
                end
                `IDX_FB_DIVS:
                begin
                    fba[7:0] <= wr_word[`FBA_LO_MSB:`FBA_LO_LSB];
                    fbb      <= wr_word[`FBB_MSB:0];
                end
                default:
                    fbb <= fbb;
            endcase
        end
    end

    // Launch a snapshot to the system domain when the last one is taken
    always_ff @(posedge link_clk_i)
    begin
        ack_s1 <= ack_t;
        ack_s2 <= ack_s1;
        if (link_rst)
        begin
            dirty <= 1'b0;
            req_t <= 1'b0;
        end
        else if (dirty && req_t == ack_s2)
        begin
            snap  <= {cap, res, pump, refdiv, fba, fbb};
            req_t <= ~req_t;
            dirty <= commit;
        end
        else
            dirty <= dirty | commit;
    end

    // System side: load outputs on each new request toggle
    always_ff @(posedge sys_clk_i)
    begin
        req_s1 <= req_t;
        req_s2 <= req_s1;
        if (srst_i)
        begin
            req_s3               <= 1'b0;
            ack_t                <= 1'b0;
            loop_cap_sel_o       <= `CAP_RST;
            loop_res_sel_o       <= `RES_RST;
            pump_current_sel_o   <= `PUMP_RST;
            ref_divider_o        <= `REFDIV_RST;
            feedback_divider_a_o <= `FBA_RST;
            feedback_divider_b_o <= `FBB_RST;
        end
        else
        begin
            req_s3 <= req_s2;
            ack_t  <= req_s3;
            if (req_s2 != req_s3)
                {loop_cap_sel_o, loop_res_sel_o, pump_current_sel_o, ref_divider_o,
                 feedback_divider_a_o, feedback_divider_b_o} <= snap;
        end
    end

    // Checks of the link-side behaviour
    sequence s_start;
        start_det && bus_en;
    endsequence
    sequence s_addr_begun;
        state == ST_ADDR && bitcnt == 4'h0;
    endsequence

    property p_quiet_off;
        @(posedge link_clk_i) disable iff (link_rst)
        !bus_en |=> sda_oe_n_o;
    endproperty
    a_quiet_off: assert property (p_quiet_off) else $error("driving while disabled");

    property p_start;
        @(posedge link_clk_i) disable iff (link_rst)
        s_start |=> s_addr_begun;
    endproperty
    a_start: assert property (p_start) else $error("start not taken");

    property p_match;
        @(posedge link_clk_i) disable iff (link_rst)
        $rose(state == ST_ADDR_AK) |-> $past(shreg[7:1]) == {`SLAVE_ADDR_HI, addr_lo};
    endproperty
    a_match: assert property (p_match) else $error("ack of foreign address");

    property p_addr_ack;
        @(posedge link_clk_i) disable iff (link_rst)
        state == ST_ADDR_AK |-> !sda_oe_n_o;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("address not acked");

    property p_change_low;
        @(posedge link_clk_i) disable iff (link_rst)
        $changed(sda_oe_n_o) && !$past(start_det || stop_det) && $past(bus_en) |-> !scl_f;
    endproperty
    a_change_low: assert property (p_change_low) else $error("data moved with clock high");

    property p_nack_idle;
        @(posedge link_clk_i) disable iff (link_rst)
        state == ST_RD_AK && scl_fall && nack && !start_det && !stop_det && bus_en
            |=> state == ST_IDLE && sda_oe_n_o [*2];
    endproperty
    a_nack_idle: assert property (p_nack_idle) else $error("read not ended on nack");

    property p_cut_short;
        @(posedge link_clk_i) disable iff (link_rst)
        stop_det && state == ST_WR |=> !commit ##1 $stable(refdiv) && $stable(cap);
    endproperty
    a_cut_short: assert property (p_cut_short) else $error("partial write landed");

    property p_byte_len;
        @(posedge link_clk_i) disable iff (link_rst)
        $rose(state == ST_WR_AK) |-> $past(bitcnt) == 4'h8;
    endproperty
    a_byte_len: assert property (p_byte_len) else $error("byte not eight bits");
endmodule
`default_nettype wire

// [verif/i2c_master_model.sv]
/*
 Behavioural two-wire bus master: start, stop, byte write and byte read.
 Assumes an external pull-up resolves the data line from sda_low_o.
*/
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
    output var logic scl_o,
    output var logic sda_low_o,
    input  wire logic sda_i
);
    int   q_ns   = 250;  // Quarter bit period
    logic glitch = 1'b0; // Short SCL pulse inside the low phase of each bit

    // Bus idles released
    initial
    begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end

    // One bit: data moves only while SCL is low
    task automatic xfer_bit(input logic b, output logic r);
        sda_low_o = ~b;
        #(q_ns);
        scl_o = 1'b1;
        #(q_ns);
        r = sda_i;
        #(q_ns);
        scl_o = 1'b0;
        #(q_ns / 2);
        if (glitch)
        begin
            scl_o = 1'b1;
            #20;
            scl_o = 1'b0;
        end
        #(q_ns / 2);
    endtask

    // Start or repeated start
    task automatic start();
        sda_low_o = 1'b0;
        #(q_ns);
        scl_o = 1'b1;
        #(q_ns);
        sda_low_o = 1'b1;
        #(q_ns);
        scl_o = 1'b0;
        #(q_ns);
    endtask

    // Stop: data low before the pulse, released while SCL is high
    task automatic stop();
        sda_low_o = 1'b1;
        #(q_ns);
        scl_o = 1'b1;
        #(q_ns);
        sda_low_o = 1'b0;
        #(q_ns);
    endtask

    // Byte out MSB first, acknowledge sampled in the ninth pulse
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            xfer_bit(d[i], r);
        xfer_bit(1'b1, r);
        ack = (r === 1'b0);
    endtask

    // Byte in MSB first; last byte gets a not-acknowledge
    task automatic read_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            xfer_bit(1'b1, d[i]);
        xfer_bit(last, r);
    endtask
endmodule
`default_nettype wire

// [verif/i2c_pll_cfg_tb_top.sv]
/*
 Self-checking bench of the configuration port: writes, reads, address
 mismatch, partial write, slow bus with glitches and disabled port.
 Assumes the master model drives the bus pins and a pull-up on data.
*/
`include "pll_cfg_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module i2c_pll_cfg_tb_top
    import pll_cfg_pkg::*;
;
    localparam logic [6:0] BASE = {`SLAVE_ADDR_HI, 2'b10};
    logic sys_clk_i, srst_i, link_clk_i, scl, sda_low, sda_bus, sda_o, sda_oe_n_o;
    logic ad_hi, ad_lo, sel_hi, sel_lo, dev_rst_n, ak;
    logic [2:0]  loop_cap_sel_o, loop_res_sel_o, pump_current_sel_o;
    logic [13:0] ref_divider_o;
    logic [9:0]  feedback_divider_a_o;
    logic [7:0]  feedback_divider_b_o;
    logic [15:0] w;
    int          fail_count = 0;
    int          checked    = 0;

    // Clocks with unrelated phases
    initial
    begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    initial
    begin
        link_clk_i = 1'b0;
        #1.3;
        forever #3 link_clk_i = ~link_clk_i;
    end

    // Open-drain data line with pull-up
    assign sda_bus = (sda_low || !sda_oe_n_o) ? 1'b0 : 1'b1;

    i2c_pll_cfg #(.LINK_CLK_MHZ(167)) u_dut (
        .sys_clk_i(sys_clk_i), .srst_i(srst_i), .link_clk_i(link_clk_i),
        .scl_i(scl), .sda_i(sda_bus), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
        .addr_select_hi_pin_i(ad_hi), .addr_select_lo_pin_i(ad_lo),
        .iface_sel_hi_i(sel_hi), .iface_sel_lo_i(sel_lo),
        .device_reset_low_i(dev_rst_n), .loop_cap_sel_o(loop_cap_sel_o),
        .loop_res_sel_o(loop_res_sel_o), .pump_current_sel_o(pump_current_sel_o),
        .ref_divider_o(ref_divider_o), .feedback_divider_a_o(feedback_divider_a_o),
        .feedback_divider_b_o(feedback_divider_b_o)
    );
    i2c_master_model u_m (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda_bus));

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Write: address, index, data bytes, stop; then let the snapshot cross
    task automatic reg_write(input logic [6:0] a7, input logic [7:0] bq[$], output logic acked);
        logic a;
        u_m.start();
        u_m.write_byte({a7, 1'b0}, acked);
        foreach (bq[i])
        begin
            u_m.write_byte(bq[i], a);
            acked &= a;
        end
        u_m.stop();
        repeat (40) @(negedge sys_clk_i);
    endtask

    // Read one word with a repeated start
    task automatic reg_read(input logic [7:0] idx, output logic [15:0] d);
        logic a;
        u_m.start();
        u_m.write_byte({BASE, 1'b0}, a);
        u_m.write_byte(idx, a);
        u_m.start();
        u_m.write_byte({BASE, 1'b1}, a);
        u_m.read_byte(1'b0, d[15:8]);
        u_m.read_byte(1'b1, d[7:0]);
        u_m.stop();
        repeat (10) @(negedge sys_clk_i);
    endtask

    // Compare every output field against three register words
    task automatic chk_cfg(input logic [15:0] r0, input logic [15:0] r1, input logic [15:0] r2);
        check("cap", {13'h0, loop_cap_sel_o}, {13'h0, r0[9:7]});
        check("res", {13'h0, loop_res_sel_o}, {13'h0, r0[6:4]});
        check("pump", {13'h0, pump_current_sel_o}, {13'h0, r0[3:1]});
        check("refdiv", {2'h0, ref_divider_o}, {2'h0, r1[15:2]});
        check("fba", {6'h0, feedback_divider_a_o}, {6'h0, r1[1:0], r2[15:8]});
        check("fbb", {8'h0, feedback_divider_b_o}, {8'h0, r2[7:0]});
    endtask

    // Hang guard: the tests take about 735 us
    initial
    begin
        #800000;
        fail_count++;
        tally_and_finish();
    end

    // Main sequence
    initial
    begin
        static logic [7:0]  idx[4] = '{8'h00, 8'h01, 8'h02, 8'h05};
        static logic [15:0] exp[4] = '{16'h03FE, 16'hABCD, 16'h965A, 16'h0000};
        static logic [6:0]  bad[4] = '{7'h55, 7'h54, 7'h57, 7'h16};
        srst_i = 1'b1;
        {ad_hi, ad_lo, sel_hi, sel_lo, dev_rst_n} = 5'b10011;
        repeat (8) @(negedge sys_clk_i);
        srst_i = 1'b0;
        repeat (20) @(negedge sys_clk_i);
        {ad_hi, ad_lo} = 2'b01; // Later pin changes must be ignored
        chk_cfg(16'h0000, 16'h0000, 16'h0000);
        $display("Test reset done");
        reg_write(BASE, '{8'h00, 8'hFF, 8'hFF, 8'hAB, 8'hCD, 8'h96, 8'h5A}, ak);
        check("ack", {15'h0, ak}, 16'h0001);
        chk_cfg(16'hFFFF, 16'hABCD, 16'h965A);
        $display("Test burst write done");
        for (int i = 0; i < 4; i++)
        begin
            reg_read(idx[i], w);
            check("rdata", w, exp[i]);
            check("release", {14'h0, sda_o, sda_oe_n_o}, 16'h0001);
        end
        $display("Test readback done");
        reg_write(BASE, '{8'h02, 8'h11}, ak);
        chk_cfg(16'hFFFF, 16'hABCD, 16'h965A);
        $display("Test partial write done");
        u_m.q_ns   = 625;
        u_m.glitch = 1'b1;
        reg_write(BASE, '{8'h00, 8'h02, 8'hD4}, ak);
        u_m.glitch = 1'b0;
        u_m.q_ns   = 250;
        chk_cfg(16'h02D4, 16'hABCD, 16'h965A);
        $display("Test slow bus with glitches done");
        for (int i = 0; i < 4; i++)
        begin
            reg_write(bad[i], '{8'h00, 8'h00, 8'h00}, ak);
            check("nack", {15'h0, ak}, 16'h0000);
        end
        $display("Test address mismatch done");
        for (int j = 0; j < 5; j++)
        begin
            @(negedge sys_clk_i);
            {sel_hi, sel_lo} = (j == 4) ? 2'b01 : j[1:0];
            dev_rst_n = (j != 4);
            reg_write(BASE, '{8'h03, 8'h12, 8'h34}, ak);
            check("enable", {15'h0, ak}, {15'h0, j == 1});
        end
        @(negedge sys_clk_i);
        dev_rst_n = 1'b1;
        chk_cfg(16'h02D4, 16'hABCD, 16'h965A);
        $display("Test port disable done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
